/* rtl/dles_cfg.svh */
// Behaviour
// - lanes 2 and 3: bit 4 set on uncorrectable end-of-transmission sync error
// - lanes 2 and 3: bit 3 set on correctable start sync bit error
// - lanes 2 and 3: bit 2 set on uncorrectable start sync sequence error
// - lanes 2 and 3: bit 1 set on illegal control in high-speed request
// - lanes 2 and 3: bit 0 set when high-speed reception exceeds timeout
// - lane 2 flags at 0x12, lane 3 at 0x13, reset zero, bits 7-5 zero
// - clock-lane flags at 0x14, reset zero, bits 7-4 read zero
// - summary status bit 5 high while any lane error flag is set
// - summary clears once software has read the lane error registers
// - timeout counts 1 ms steps from 8-bit limit; zero disables it
`ifndef DLES_CFG_SVH
`define DLES_CFG_SVH

// register indices; byte address is four times the index
`define DLES_IDX_TIMEOUT_LIMIT   8'h08
`define DLES_IDX_STATUS          8'h0f
`define DLES_IDX_LANE2_FLAGS     8'h12
`define DLES_IDX_LANE3_FLAGS     8'h13
`define DLES_IDX_CLK_LANE_FLAGS  8'h14

// field positions
`define DLES_BIT_END_SYNC        4
`define DLES_BIT_START_BITFLIP   3
`define DLES_BIT_START_SYNC      2
`define DLES_BIT_HS_REQ_CTRL     1
`define DLES_BIT_HS_TIMEOUT      0
`define DLES_BIT_SUMMARY         5
`define DLES_BIT_LANE3_ACTIVE    3
`define DLES_BIT_LANE2_ACTIVE    2

// reset values
`define DLES_RST_LANE_FLAGS      5'h00
`define DLES_RST_CLK_FLAGS       4'h0
`define DLES_RST_TIMEOUT_LIMIT   8'h00

// timing
`define DLES_CORE_CLK_PERIOD_NS  25
`define DLES_TIMEOUT_STEP_MS     1
`define DLES_STEP_CYCLES         ((`DLES_TIMEOUT_STEP_MS * 1000000) / `DLES_CORE_CLK_PERIOD_NS)

`endif

/* rtl/dles_pkg.sv */
package dles_pkg;

  // per data lane sticky flags, msb first as in the register
  typedef struct packed {
    logic end_sync_fault;
    logic start_bitflip;
    logic start_sync_fault;
    logic hs_request_ctrl_fault;
    logic hs_receive_timeout;
  } dles_lane_flags_t;

  // captured ahb address phase
  typedef struct packed {
    logic       valid;
    logic       write;
    logic [7:0] index;
  } dles_ahb_phase_t;

endpackage : dles_pkg

/* rtl/dles_lane_err_top.sv */
`timescale 1ns/1ps
`include "dles_cfg.svh"

module dles_lane_err_top #(
  parameter int STEP_CYCLES = `DLES_STEP_CYCLES
) (
  input  wire logic        CORE_CLK,
  input  wire logic        RSTN,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic        HREADY,
  input  wire logic [31:0] HWDATA,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // link side, on the receiver byte clock
  input  wire logic        LINK_CLK,
  input  wire logic        LINK_RSTN,
  input  wire logic [3:0]  LANE2_FAULT_EVT,
  input  wire logic [3:0]  LANE3_FAULT_EVT,
  input  wire logic [3:0]  CLK_LANE_FAULT_EVT,
  input  wire logic        LANE2_HS_RX_ACTIVE,
  input  wire logic        LANE3_HS_RX_ACTIVE,
  output logic             ANY_LANE_FAULT_SUMMARY
);

  localparam int NEVT = 12;

  // address decode shared by reads, clears and writes
  function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] idx);
    reg_hit = (addr[31:2] == {22'h000000, idx}) && (addr[1:0] == 2'h0);
  endfunction : reg_hit

  // ------------------------------------------------------------------
  // link domain: each fault pulse flips a toggle
  // ------------------------------------------------------------------
  logic [NEVT-1:0] link_raw;
  logic [NEVT-1:0] link_raw_d_r;
  logic [NEVT-1:0] link_evt;
  logic [NEVT-1:0] link_tog_r;
  logic [1:0]      link_act_r;

  // all fault sources side by side: clock lane, lane 3, lane 2
  assign link_raw = {CLK_LANE_FAULT_EVT, LANE3_FAULT_EVT, LANE2_FAULT_EVT};

  // previous level, so a source held high counts as one event
  always_ff @(posedge LINK_CLK) begin
    if (!LINK_RSTN) begin
      link_raw_d_r <= 12'h000;
    end else begin
      link_raw_d_r <= link_raw;
    end
  end

  // rising edges only; every source idles low, so no edge after reset
  assign link_evt = link_raw & ~link_raw_d_r;

  // event toggles, one per fault source
  always_ff @(posedge LINK_CLK) begin
    if (!LINK_RSTN) begin
      link_tog_r <= 12'h000;
    end else begin
      link_tog_r <= link_tog_r ^ link_evt;
    end
  end

  // registered activity levels so the crossing sees clean edges
  always_ff @(posedge LINK_CLK) begin
    if (!LINK_RSTN) begin
      link_act_r <= 2'h0;
    end else begin
      link_act_r <= {LANE3_HS_RX_ACTIVE, LANE2_HS_RX_ACTIVE};
    end
  end

  // ------------------------------------------------------------------
  // crossing into the core domain, three stages each
  // ------------------------------------------------------------------
  logic [NEVT-1:0] tog_s1_r;
  logic [NEVT-1:0] tog_s2_r;
  logic [NEVT-1:0] tog_s3_r;
  logic [NEVT-1:0] evt_pulse;
  logic [1:0]      act_s1_r;
  logic [1:0]      act_s2_r;
  logic [1:0]      act_s3_r;
  logic [1:0]      hs_active;
  logic [1:0]      hs_active_r;

  genvar gi;
  generate
    for (gi = 0; gi < NEVT; gi++) begin : g_evt_sync
      // toggle synchroniser; pulse when stages two and three differ
      always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
          tog_s1_r[gi] <= 1'b0;
          tog_s2_r[gi] <= 1'b0;
          tog_s3_r[gi] <= 1'b0;
        end else begin
          tog_s1_r[gi] <= link_tog_r[gi];
          tog_s2_r[gi] <= tog_s1_r[gi];
          tog_s3_r[gi] <= tog_s2_r[gi];
        end
      end
      assign evt_pulse[gi] = tog_s2_r[gi] ^ tog_s3_r[gi];
    end
    for (gi = 0; gi < 2; gi++) begin : g_act_sync
      // level synchroniser; a change counts once stages two and three agree
      always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
          act_s1_r[gi] <= 1'b0;
          act_s2_r[gi] <= 1'b0;
          act_s3_r[gi] <= 1'b0;
        end else begin
          act_s1_r[gi] <= link_act_r[gi];
          act_s2_r[gi] <= act_s1_r[gi];
          act_s3_r[gi] <= act_s2_r[gi];
        end
      end
      // level taken over only once stages two and three agree
      always_ff @(posedge CORE_CLK) begin
        if (!RSTN) begin
          hs_active_r[gi] <= 1'b0;
        end else if (act_s2_r[gi] == act_s3_r[gi]) begin
          hs_active_r[gi] <= act_s3_r[gi];
        end
      end
      assign hs_active[gi] = hs_active_r[gi];
    end
  endgenerate

  // ------------------------------------------------------------------
  // ahb-lite slave: zero wait states, always okay
  // ------------------------------------------------------------------
  dles_pkg::dles_ahb_phase_t dphase_r;
  logic                      accept;
  logic                      rd_accept;
  logic [7:0]                limit_r;
  logic [7:0]                limit_nxt;
  logic [31:0]               rdata_nxt;
  logic [31:0]               hrdata_r;
  logic                      sel_limit;
  logic                      sel_status;
  logic                      sel_lane2;
  logic                      sel_lane3;
  logic                      sel_clk;

  // transfer taken at this edge; the slave never inserts a wait state
  assign accept    = HSEL & HTRANS[1] & HREADY;
  assign rd_accept = accept & ~HWRITE;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_r;

  // register decode, shared by reads, read-clears and writes
  assign sel_limit  = reg_hit(HADDR, `DLES_IDX_TIMEOUT_LIMIT);
  assign sel_status = reg_hit(HADDR, `DLES_IDX_STATUS);
  assign sel_lane2  = reg_hit(HADDR, `DLES_IDX_LANE2_FLAGS);
  assign sel_lane3  = reg_hit(HADDR, `DLES_IDX_LANE3_FLAGS);
  assign sel_clk    = reg_hit(HADDR, `DLES_IDX_CLK_LANE_FLAGS);

  // capture the address phase for the following data phase
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      dphase_r <= '0;
    end else if (HREADY) begin
      dphase_r.valid <= accept & HWRITE & sel_limit;
      dphase_r.write <= HWRITE;
      dphase_r.index <= HADDR[9:2];
    end
  end

  // timeout limit, written in the data phase
  always_comb begin
    limit_nxt = limit_r;
    if (dphase_r.valid && dphase_r.index == `DLES_IDX_TIMEOUT_LIMIT) begin
      limit_nxt = HWDATA[7:0];
    end
  end

  // limit register itself
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      limit_r <= `DLES_RST_TIMEOUT_LIMIT;
    end else begin
      limit_r <= limit_nxt;
    end
  end

  // ------------------------------------------------------------------
  // high-speed receive timeout
  // ------------------------------------------------------------------
  logic [15:0] step_cnt_r;
  logic        step_tick;
  logic [7:0]  lane_ms_r [2];
  logic [1:0]  timeout_evt;
  logic [1:0]  tmo_done_r;

  // last cycle of each 1 ms step
  assign step_tick = (step_cnt_r == 16'(STEP_CYCLES - 1));

  // free-running 1 ms step prescaler
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN || step_tick) begin
      step_cnt_r <= 16'h0000;
    end else begin
      step_cnt_r <= step_cnt_r + 16'h0001;
    end
  end

  generate
    for (gi = 0; gi < 2; gi++) begin : g_timeout
      always_ff @(posedge CORE_CLK) begin
        if (!RSTN || !hs_active[gi]) begin
          lane_ms_r[gi] <= 8'h00;
        end else if (step_tick && lane_ms_r[gi] != 8'hff) begin
          lane_ms_r[gi] <= lane_ms_r[gi] + 8'h01;
        end
      end
      assign timeout_evt[gi] = hs_active[gi] & step_tick & (limit_r != 8'h00) &
                               ~tmo_done_r[gi] & ((lane_ms_r[gi] + 8'h01) == limit_r);
      always_ff @(posedge CORE_CLK) begin
        if (!RSTN || !hs_active[gi]) begin
          tmo_done_r[gi] <= 1'b0;
        end else if (timeout_evt[gi]) begin
          tmo_done_r[gi] <= 1'b1;
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------------
  // sticky flags, cleared by a read
  // ------------------------------------------------------------------
  dles_pkg::dles_lane_flags_t lane2_r;
  dles_pkg::dles_lane_flags_t lane3_r;
  dles_pkg::dles_lane_flags_t lane2_set;
  dles_pkg::dles_lane_flags_t lane3_set;
  logic [3:0]                 clk_lane_r;
  logic                       clr_lane2;
  logic                       clr_lane3;
  logic                       clr_clk;

  assign clr_lane2 = rd_accept & sel_lane2;
  assign clr_lane3 = rd_accept & sel_lane3;
  assign clr_clk   = rd_accept & sel_clk;

  // map crossed events onto lane fields
  always_comb begin
    lane2_set.end_sync_fault        = evt_pulse[3];
    lane3_set.end_sync_fault        = evt_pulse[7];
    lane2_set.start_bitflip         = evt_pulse[2];
    lane3_set.start_bitflip         = evt_pulse[6];
    lane2_set.start_sync_fault      = evt_pulse[1];
    lane3_set.start_sync_fault      = evt_pulse[5];
    lane2_set.hs_request_ctrl_fault = evt_pulse[0];
    lane3_set.hs_request_ctrl_fault = evt_pulse[4];
    lane2_set.hs_receive_timeout    = timeout_evt[0];
    lane3_set.hs_receive_timeout    = timeout_evt[1];
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      lane2_r <= `DLES_RST_LANE_FLAGS;
    end else begin
      lane2_r <= (lane2_r & {5{~clr_lane2}}) | lane2_set;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      lane3_r <= `DLES_RST_LANE_FLAGS;
    end else begin
      lane3_r <= (lane3_r & {5{~clr_lane3}}) | lane3_set;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      clk_lane_r <= `DLES_RST_CLK_FLAGS;
    end else begin
      clk_lane_r <= (clk_lane_r & {4{~clr_clk}}) | evt_pulse[11:8];
    end
  end

  logic summary;
  assign summary = (|lane2_r) | (|lane3_r) | (|clk_lane_r);

  // summary pin, one cycle behind the flags
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      ANY_LANE_FAULT_SUMMARY <= 1'b0;
    end else begin
      ANY_LANE_FAULT_SUMMARY <= summary;
    end
  end

  // ------------------------------------------------------------------
  // read data, registered into the data phase
  // ------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 32'h00000000;
    if (sel_limit) begin
      rdata_nxt[7:0] = limit_nxt;
    end else if (sel_status) begin
      rdata_nxt[`DLES_BIT_SUMMARY]      = summary;
      rdata_nxt[`DLES_BIT_LANE3_ACTIVE] = hs_active[1];
      rdata_nxt[`DLES_BIT_LANE2_ACTIVE] = hs_active[0];
    end else if (sel_lane2) begin
      rdata_nxt[4:0] = lane2_r;
    end else if (sel_lane3) begin
      rdata_nxt[4:0] = lane3_r;
    end else if (sel_clk) begin
      rdata_nxt[3:0] = clk_lane_r;
    end
  end

  // read data held until the next accepted read
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      hrdata_r <= 32'h00000000;
    end else if (rd_accept) begin
      hrdata_r <= rdata_nxt;
    end
  end

endmodule : dles_lane_err_top

/* bench/dles_lane_err_chk.sv */
`timescale 1ns/1ps

module dles_lane_err_chk (
  input wire logic        CORE_CLK,
  input wire logic        RSTN,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic [3:0]  LANE2_FAULT_EVT,
  input wire logic [3:0]  LANE3_FAULT_EVT,
  input wire logic [3:0]  CLK_LANE_FAULT_EVT,
  input wire logic        ANY_LANE_FAULT_SUMMARY
);
  logic [7:0] rd_idx_r;
  logic       take_rd;

  // read accepted at this edge
  assign take_rd = HSEL & HTRANS[1] & HREADY & ~HWRITE;

  // index of the last accepted read, 8'hff for a miss
  always_ff @(posedge CORE_CLK) begin
    if (!RSTN) begin
      rd_idx_r <= 8'h00;
    end else if (take_rd) begin
      rd_idx_r <= (HADDR[31:10] == 22'h0 && HADDR[1:0] == 2'h0) ? HADDR[9:2] : 8'hff;
    end
  end

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);

  AST_NO_WAIT: assert property (HREADYOUT == 1'b1) else $error("wait state seen");
  AST_OKAY: assert property (HRESP == 1'b0) else $error("error response seen");
  AST_UPPER_ZERO: assert property (HRDATA[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_DATA_RSVD: assert property (rd_idx_r inside {8'h12, 8'h13} |-> HRDATA[7:5] == 3'h0)
    else $error("data lane reserved bits set");
  AST_CLK_RSVD: assert property (rd_idx_r == 8'h14 |-> HRDATA[7:4] == 4'h0)
    else $error("clock lane reserved bits set");
  AST_SUM_ON_READ: assert property ($past(take_rd) && rd_idx_r inside {8'h12, 8'h13, 8'h14}
    && HRDATA[4:0] != 5'h0 |-> ANY_LANE_FAULT_SUMMARY) else $error("flag read without summary");
  AST_SUM_FALL: assert property ($fell(ANY_LANE_FAULT_SUMMARY) |-> $past(take_rd, 2))
    else $error("summary fell without a read");
  AST_EVT_SUM: assert property (|{LANE2_FAULT_EVT, LANE3_FAULT_EVT, CLK_LANE_FAULT_EVT}
    |-> ##[0:12] ANY_LANE_FAULT_SUMMARY) else $error("fault event did not raise summary");
  AST_STS_RSVD: assert property (rd_idx_r == 8'h0f |-> HRDATA[7:6] == 2'h0 && !HRDATA[4]
    && HRDATA[1:0] == 2'h0) else $error("status reserved bits set");

  // main scenarios
  COV_LANE_READ: cover property (take_rd && HADDR[9:2] == 8'h12);
  COV_SUM_FALL: cover property ($fell(ANY_LANE_FAULT_SUMMARY));
  COV_CLK_EVT: cover property (CLK_LANE_FAULT_EVT != 4'h0);
endmodule : dles_lane_err_chk

bind dles_lane_err_top dles_lane_err_chk i_chk (.CORE_CLK, .RSTN, .HSEL, .HADDR, .HTRANS,
  .HWRITE, .HREADY, .HRDATA, .HREADYOUT, .HRESP, .LANE2_FAULT_EVT, .LANE3_FAULT_EVT,
  .CLK_LANE_FAULT_EVT, .ANY_LANE_FAULT_SUMMARY);

/* bench/dles_link_host.sv */
`timescale 1ns/1ps

module dles_link_host (
  input  wire logic       link_clk,
  output logic      [3:0] lane2_evt,
  output logic      [3:0] lane3_evt,
  output logic      [3:0] clk_evt,
  output logic            lane2_hs,
  output logic            lane3_hs
);
  // idle link: no faults, no bursts
  initial begin
    {lane2_evt, lane3_evt, clk_evt} = 12'h000;
    {lane2_hs, lane3_hs} = 2'h0;
  end

  task automatic pulse(input logic [1:0] sel, input logic [3:0] bits);
    @(posedge link_clk);
    case (sel)
      2'h2: lane2_evt <= bits;
      2'h3: lane3_evt <= bits;
      default: clk_evt <= bits;
    endcase
    @(posedge link_clk);
    {lane2_evt, lane3_evt, clk_evt} <= 12'h000;
  endtask : pulse

  // start or end a high-speed burst
  task automatic burst(input logic [1:0] sel, input logic lvl);
    @(posedge link_clk);
    if (sel == 2'h2) lane2_hs <= lvl;
    else lane3_hs <= lvl;
  endtask : burst
endmodule : dles_link_host

/* bench/tb_dles_lane_err_top.sv */
`timescale 1ns/1ps

module tb_dles_lane_err_top;
  localparam int STEP = 20;
  logic        core_clk, rstn, link_clk, link_rstn, hsel, hwrite, hreadyout, hresp, summary;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, q;
  logic [3:0]  l2e, l3e, ce;
  logic        l2h, l3h;
  logic [31:0] regs [5] = '{32'h48, 32'h4c, 32'h50, 32'h20, 32'h3c};
  int          n_fail, tests_run;

  dles_lane_err_top #(.STEP_CYCLES(STEP)) i_dut (.CORE_CLK(core_clk), .RSTN(rstn),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .LINK_CLK(link_clk), .LINK_RSTN(link_rstn), .LANE2_FAULT_EVT(l2e),
    .LANE3_FAULT_EVT(l3e), .CLK_LANE_FAULT_EVT(ce), .LANE2_HS_RX_ACTIVE(l2h),
    .LANE3_HS_RX_ACTIVE(l3h), .ANY_LANE_FAULT_SUMMARY(summary));
  dles_link_host i_host (.link_clk(link_clk), .lane2_evt(l2e), .lane3_evt(l3e),
    .clk_evt(ce), .lane2_hs(l2h), .lane3_hs(l3h));

  // clocks, link clock offset in phase
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #62.5 link_clk = ~link_clk;
  end

  // one single ahb transfer
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic rd_chk(input string nm, input logic [31:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(nm, e, q);
  endtask : rd_chk

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // link reset spans three link edges
  initial begin
    link_rstn = 1'b0;
    repeat (3) @(posedge link_clk);
    link_rstn <= 1'b1;
  end

  // watchdog
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    give_verdict();
  end

  // main sequence
  initial begin
    logic [31:0] exp;
    {rstn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    n_fail = 0;
    tests_run = 0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (20) @(posedge core_clk);
    foreach (regs[i]) rd_chk("reset", regs[i], 32'h0);
    ahb(1'b1, 32'h30, 32'hff);
    rd_chk("unmapped", 32'h30, 32'h0);
    ahb(1'b1, 32'h48, 32'hff);
    rd_chk("read only", 32'h48, 32'h0);
    ahb(1'b1, 32'h20, 32'h1a5);
    rd_chk("limit", 32'h20, 32'ha5);
    $display("test registers done");
    for (int s = 2; s <= 4; s++) begin
      for (int b = 0; b < 4; b++) begin
        exp = (s == 4) ? (32'h1 << b) : (32'h2 << b);
        i_host.pulse(s[1:0], 4'h1 << b);
        repeat (12) @(posedge core_clk);
        chk("summary", 32'h1, {31'h0, summary});
        rd_chk("flags", 32'h40 + 4 * s, exp);
        rd_chk("cleared", 32'h40 + 4 * s, 32'h0);
        repeat (2) @(posedge core_clk);
        chk("summary", 32'h0, {31'h0, summary});
      end
    end
    // a read that meets the flag's setting edge must not lose the flag
    for (int k = 0; k < 4; k++) begin
      i_host.pulse(2'h3, 4'h8);
      repeat (k) @(posedge core_clk);
      ahb(1'b0, 32'h4c, 32'h0);
      exp = q;
      repeat (8) @(posedge core_clk);
      rd_chk("race", 32'h4c, 32'h10 ^ exp);
    end
    $display("test faults done");
    ahb(1'b1, 32'h20, 32'h0);
    i_host.burst(2'h2, 1'b1);
    repeat (10 * STEP) @(posedge core_clk);
    rd_chk("status", 32'h3c, 32'h4);
    rd_chk("timeout off", 32'h48, 32'h0);
    i_host.burst(2'h2, 1'b0);
    ahb(1'b1, 32'h20, 32'h2);
    i_host.burst(2'h3, 1'b1);
    repeat (10) @(posedge core_clk);
    rd_chk("early", 32'h3c, 32'h8);
    repeat (3 * STEP) @(posedge core_clk);
    rd_chk("status", 32'h3c, 32'h28);
    i_host.burst(2'h3, 1'b0);
    rd_chk("timeout", 32'h4c, 32'h1);
    rd_chk("cleared", 32'h4c, 32'h0);
    $display("test timeout done");
    give_verdict();
  end
endmodule : tb_dles_lane_err_top
